// [rtl/hlc_loop_end_ctrl.sv]
// hardware loop end-of-iteration controller with wishbone loop registers
//
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`include "hlc_defines.svh"

module hlc_loop_end_ctrl #(
  parameter int NLOOP = 4,
  parameter int LCW = 32,
  parameter int AW = 32
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic setValid,
  input wire logic prefixValid,
  input wire logic [15:0] prefixWord,
  output logic fetchRedirect,
  output logic [AW-1:0] redirectAddr,
  output hlc_pkg::hlc_slots_t delaySlots,
  output logic seqContinue,
  output logic loopEnd,
  output logic [NLOOP-1:0] loopActiveFlag,
  output logic [NLOOP-1:0] shortLoopFlag
);
  import hlc_pkg::*;

  localparam int IW = (NLOOP > 1) ? $clog2(NLOOP) : 1;

  // whole state of the block in one record
  typedef struct packed {
    logic [NLOOP-1:0][LCW-1:0] lc; // iteration counters
    logic [NLOOP-1:0][AW-1:0] sa; // loop start addresses
    logic [NLOOP-1:0] lf; // loop active flags
    logic [NLOOP-1:0] short_loop_flag; // short loop flags
    logic [1:0] ignCnt; // sets left in the ignore window
    hlc_ign_t ignKind; // marks suppressed in the window
    logic redir; // fetch redirect pulse
    logic [AW-1:0] redirAddr; // redirect target
    hlc_slots_t slots; // delay slots of the redirect
    logic seq; // sequential continue pulse
    logic endP; // loop terminated pulse
    logic ack; // wishbone acknowledge
    logic [31:0] rdat; // wishbone read data
  } hlc_state_t;

  hlc_state_t s_q; // registered state
  hlc_state_t s_d; // next state

  // highest active loop is the innermost one
  function automatic logic [IW-1:0] topIdx(input logic [NLOOP-1:0] f);
    logic [IW-1:0] r;
    r = '0;
    for (int i = 0; i < NLOOP; i++) begin
      if (f[i]) begin
        r = IW'(i);
      end
    end
    return r;
  endfunction

  // byte lane mask from wishbone selects
  function automatic logic [31:0] laneMask(input logic [3:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // marks are bits of the prefix, taken with the set that carries it
  logic lastMk; // last-set mark present
  logic earlyMk; // early mark present
  assign lastMk = setValid & prefixValid & prefixWord[`HLC_PFX_LAST_BIT];
  assign earlyMk = setValid & prefixValid & prefixWord[`HLC_PFX_EARLY_BIT];

  // active and enclosing loop selection from the flags
  logic actAny; // some loop is active
  logic [IW-1:0] actIdx; // innermost active loop
  logic outAny; // an enclosing loop exists
  logic [IW-1:0] outIdx; // enclosing loop
  logic [NLOOP-1:0] outFlags; // flags without the innermost
  assign actAny = |s_q.lf;
  assign actIdx = topIdx(s_q.lf);
  always_comb begin
    outFlags = s_q.lf;
    outFlags[actIdx] = 1'b0;
  end
  assign outAny = |outFlags;
  assign outIdx = topIdx(outFlags);

  // ignore window decode
  logic ignAll; // every mark suppressed
  logic ignLast; // last-set marks suppressed
  assign ignAll = (s_q.ignCnt != 2'h0) && (s_q.ignKind == HLC_IGN_ALL);
  assign ignLast = (s_q.ignCnt != 2'h0) && (s_q.ignKind == HLC_IGN_LAST);

  // effective marks after suppression
  logic markA; // last-set mark to execute
  logic markB; // early mark to execute
  assign markA = lastMk & ~ignAll & ~ignLast;
  assign markB = earlyMk & ~ignAll;

  // helper views of the innermost loop
  logic [LCW-1:0] actLc; // counter of the innermost loop
  logic [AW-1:0] actSa; // start of the innermost loop
  assign actLc = s_q.lc[actIdx];
  assign actSa = s_q.sa[actIdx];

  logic doB; // early mark reaches a loop
  logic [IW-1:0] bIdx; // loop the early mark acts on
  logic [31:0] rdVal; // read multiplexer
  logic [31:0] wMask; // write lane mask
  logic [7:0] regOff; // decoded offset within a bank

  // next state of loop machine and register slave
  always_comb begin
    s_d = s_q;
    s_d.redir = 1'b0;
    s_d.seq = 1'b0;
    s_d.endP = 1'b0;
    doB = 1'b0;
    bIdx = actIdx;
    rdVal = 32'h0;
    wMask = laneMask(wb_sel_i);
    regOff = 8'h0;
    // the ignore window counts executed sets
    if (setValid && (s_q.ignCnt != 2'h0)) begin
      s_d.ignCnt = s_q.ignCnt - 2'h1;
      if (s_q.ignCnt == 2'h1) begin
        s_d.ignKind = HLC_IGN_NONE;
      end
    end
    // marks are dropped while no loop is active
    if (actAny) begin
      if (markA) begin
        if (actLc > LCW'(`HLC_LC_ONE)) begin
          // another pass: direct branch, early mark of the set ignored
          s_d.lc[actIdx] = actLc - LCW'(1);
          s_d.redir = 1'b1;
          s_d.redirAddr = actSa;
          s_d.slots = HLC_SLOT0;
        end else begin
          // inner loop ends without branching
          s_d.lc[actIdx] = '0;
          s_d.lf[actIdx] = 1'b0;
          s_d.short_loop_flag[actIdx] = 1'b0;
          s_d.endP = 1'b1;
          if (markB && outAny) begin
            // early mark then belongs to the enclosing loop
            doB = 1'b1;
            bIdx = outIdx;
          end else begin
            s_d.seq = 1'b1;
          end
        end
      end else if (markB) begin
        doB = 1'b1;
      end
      if (doB) begin
        if (s_q.lc[bIdx] > LCW'(`HLC_LC_ONE)) begin
          s_d.lc[bIdx] = s_q.lc[bIdx] - LCW'(1);
          s_d.redir = 1'b1;
          s_d.redirAddr = s_q.sa[bIdx];
          if (s_q.short_loop_flag[bIdx]) begin
            // short loop: one slot, next set's marks dropped
            s_d.slots = HLC_SLOT1;
            s_d.ignCnt = `HLC_IGN_SETS_SHORT;
            s_d.ignKind = HLC_IGN_ALL;
          end else begin
            // long loop: two slots, their marks dropped
            s_d.slots = HLC_SLOT2;
            s_d.ignCnt = `HLC_IGN_SETS_LONG;
            s_d.ignKind = HLC_IGN_ALL;
          end
        end else begin
          s_d.lc[bIdx] = '0;
          s_d.lf[bIdx] = 1'b0;
          s_d.short_loop_flag[bIdx] = 1'b0;
          s_d.endP = 1'b1;
          s_d.seq = 1'b1;
          if (!s_q.short_loop_flag[bIdx]) begin
            // long loop end: a trailing last-set mark must not re-fire
            s_d.ignCnt = `HLC_IGN_SETS_LONG;
            s_d.ignKind = HLC_IGN_LAST;
          end else begin
            // short loop end: following marks are processed
            s_d.ignCnt = 2'h0;
            s_d.ignKind = HLC_IGN_NONE;
          end
        end
      end
    end
    // read mux
    if (wb_adr_i == `HLC_OFF_CTRL) begin
      rdVal[`HLC_CTRL_LF_LSB +: NLOOP] = s_q.lf;
      rdVal[`HLC_CTRL_SLF_LSB +: NLOOP] = s_q.short_loop_flag;
    end else if (wb_adr_i == `HLC_OFF_STAT) begin
      rdVal = 32'({s_q.ignKind, s_q.ignCnt, actAny, actIdx});
    end
    for (int i = 0; i < NLOOP; i++) begin
      regOff = 8'(i) * `HLC_REG_STEP;
      if (wb_adr_i == (`HLC_OFF_LC + regOff)) begin
        rdVal = 32'(s_q.lc[i]);
      end
      if (wb_adr_i == (`HLC_OFF_SA + regOff)) begin
        rdVal = 32'(s_q.sa[i]);
      end
    end
    // wishbone: ack one cycle after the request, then drop
    s_d.ack = 1'b0;
    if (wb_cyc_i && wb_stb_i && !s_q.ack) begin
      s_d.ack = 1'b1;
      s_d.rdat = rdVal;
    end
    // a write lands at the acknowledged edge and overrides the loop logic
    if (wb_cyc_i && wb_stb_i && s_q.ack && wb_we_i) begin
      if (wb_adr_i == `HLC_OFF_CTRL) begin
        s_d.lf = NLOOP'((((32'(s_q.lf) << `HLC_CTRL_LF_LSB) & ~wMask)
          | (wb_dat_i & wMask)) >> `HLC_CTRL_LF_LSB);
        s_d.short_loop_flag = NLOOP'((((32'(s_q.short_loop_flag) << `HLC_CTRL_SLF_LSB) & ~wMask)
          | (wb_dat_i & wMask)) >> `HLC_CTRL_SLF_LSB);
      end
      for (int i = 0; i < NLOOP; i++) begin
        regOff = 8'(i) * `HLC_REG_STEP;
        if (wb_adr_i == (`HLC_OFF_LC + regOff)) begin
          s_d.lc[i] = LCW'((32'(s_q.lc[i]) & ~wMask) | (wb_dat_i & wMask));
        end
        if (wb_adr_i == (`HLC_OFF_SA + regOff)) begin
          s_d.sa[i] = AW'((32'(s_q.sa[i]) & ~wMask) | (wb_dat_i & wMask));
        end
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign wb_dat_o = s_q.rdat;
  assign wb_ack_o = s_q.ack;
  assign fetchRedirect = s_q.redir;
  assign redirectAddr = s_q.redirAddr;
  assign delaySlots = s_q.slots;
  assign seqContinue = s_q.seq;
  assign loopEnd = s_q.endP;
  assign loopActiveFlag = s_q.lf;
  assign shortLoopFlag = s_q.short_loop_flag;

  // a software write in the same cycle takes over the loop state
  logic swWr; // write acknowledged this cycle
  assign swWr = wb_cyc_i & wb_stb_i & wb_we_i & s_q.ack;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  // last-set mark with another pass branches straight to the start
  AST_LAST_BRANCH: assert property (
    markA && actAny && actLc > LCW'(1) && !swWr
    |=> fetchRedirect && delaySlots == HLC_SLOT0 && redirectAddr == $past(actSa)
      && s_q.lc[$past(actIdx)] == $past(actLc) - LCW'(1))
    else $error("last-set mark did not branch and decrement");

  // lone last-set mark on the final pass ends the loop in sequence
  AST_LAST_END: assert property (
    markA && !markB && actAny && actLc <= LCW'(1) && !swWr
    |=> !fetchRedirect && seqContinue && loopEnd && !loopActiveFlag[$past(actIdx)]
      && !shortLoopFlag[$past(actIdx)])
    else $error("final last-set mark did not terminate the loop");

  // long early mark branches with two slots and opens an ignore window
  AST_LONG_EARLY: assert property (
    markB && !markA && actAny && !s_q.short_loop_flag[actIdx] && actLc > LCW'(1) && !swWr
    |=> delaySlots == HLC_SLOT2 && fetchRedirect ##0 s_q.ignKind == HLC_IGN_ALL
      && s_q.ignCnt == 2'h2)
    else $error("long early mark branch wrong");

  // no mark redirects inside an all-marks ignore window
  AST_IGN_ALL: assert property (
    ignAll && !swWr |=> !fetchRedirect && !loopEnd)
    else $error("mark acted inside the ignore window");

  // trailing last-set marks are dropped after a long loop ended early
  AST_IGN_LAST: assert property (
    ignLast && lastMk && !earlyMk |=> !fetchRedirect && !loopEnd)
    else $error("last-set mark acted after long loop end");

  // short early branch carries one slot and blocks the next set
  AST_SHORT_EARLY: assert property (
    markB && !markA && actAny && s_q.short_loop_flag[actIdx] && actLc > LCW'(1) && !swWr
    |=> delaySlots == HLC_SLOT1 && fetchRedirect && s_q.ignCnt == 2'h1)
    else $error("short early mark branch wrong");

  // short early end leaves no ignore window behind
  AST_SHORT_END: assert property (
    markB && !markA && actAny && s_q.short_loop_flag[actIdx] && actLc <= LCW'(1) && !swWr
    |=> s_q.ignCnt == 2'h0 && loopEnd && !shortLoopFlag[$past(actIdx)])
    else $error("short early end left marks suppressed");

  // both marks with inner counter above one: only the inner branch
  AST_BOTH_INNER: assert property (
    markA && markB && actAny && actLc > LCW'(1) && !swWr
    |=> fetchRedirect && delaySlots == HLC_SLOT0 && redirectAddr == $past(actSa) && s_q.ignCnt == 2'h0
      && (!$past(outAny) || s_q.lc[$past(outIdx)] == $past(s_q.lc[outIdx])))
    else $error("early mark not ignored beside inner last-set mark");

  // both marks on the inner final pass: inner ends, the early mark then acts on the outer loop
  AST_BOTH_CHAIN: assert property (
    markA && markB && actAny && outAny && actLc <= LCW'(1) && !swWr
    |=> loopEnd && !loopActiveFlag[$past(actIdx)] && (fetchRedirect != seqContinue)
      && (fetchRedirect == ($past(s_q.lc[outIdx]) > LCW'(1))))
    else $error("inner end did not pass the early mark to the outer loop");

  // a set never both redirects and continues in sequence
  AST_EXCL: assert property (
    !(fetchRedirect && seqContinue))
    else $error("redirect and sequential continue together");

endmodule // hlc_loop_end_ctrl

// [rtl/hlc_defines.svh]
// constants of the hardware loop end-mark controller
`ifndef HLC_DEFINES_SVH
`define HLC_DEFINES_SVH

// register byte offsets on the wishbone slave
`define HLC_OFF_CTRL 8'h00
`define HLC_OFF_STAT 8'h04
`define HLC_OFF_LC 8'h10
`define HLC_OFF_SA 8'h20

// width of one register slot in bytes
`define HLC_REG_STEP 8'h04

// field positions inside the control register
`define HLC_CTRL_LF_LSB 0
`define HLC_CTRL_SLF_LSB 8

// mark bit positions inside the first prefix word
`define HLC_PFX_LAST_BIT 3
`define HLC_PFX_EARLY_BIT 4

// lengths of the mark-ignore windows in execution sets
`define HLC_IGN_SETS_LONG 2'h2
`define HLC_IGN_SETS_SHORT 2'h1

// iteration count threshold for another pass
`define HLC_LC_ONE 1

`endif

// [rtl/hlc_pkg.sv]
// shared types of the hardware loop end-mark controller
package hlc_pkg;

  // delay slots attached to a fetch redirect
  typedef enum logic [1:0] {
    HLC_SLOT0 = 2'h0,
    HLC_SLOT1 = 2'h1,
    HLC_SLOT2 = 2'h3
  } hlc_slots_t;

  // which marks are suppressed in the ignore window
  typedef enum logic [1:0] {
    HLC_IGN_NONE = 2'h0,
    HLC_IGN_ALL = 2'h1,
    HLC_IGN_LAST = 2'h3
  } hlc_ign_t;

endpackage

// [verification/hlc_fetch_model.sv]
// fetch and dispatch pipeline model that issues execution sets to the loop end controller
`timescale 1ns/1ps
`include "hlc_defines.svh"

module hlc_fetch_model (
  input wire logic ref_clk,
  input wire logic arst_n,
  output logic setValid,
  output logic prefixValid,
  output logic [15:0] prefixWord
);
  // quiet pipeline at time zero
  initial begin
    setValid = 1'h0;
    prefixValid = 1'h0;
    prefixWord = 16'h0000;
  end

  // issue one execution set; the marks ride only as bits of its prefix word
  task automatic send(input logic pv, input logic early, input logic last);
    logic [15:0] w;
    w = 16'h9060; // one-word prefix form with both mark bits clear
    w[`HLC_PFX_EARLY_BIT] = early;
    w[`HLC_PFX_LAST_BIT] = last;
    @(posedge ref_clk);
    setValid <= arst_n;
    prefixValid <= pv;
    // without a prefix the word is garbage, so it toggles rather than holding stale marks
    prefixWord <= pv ? w : ~prefixWord;
  endtask

  // no set this cycle; the word keeps changing so a stale mark cannot pass for a real one
  task automatic idle();
    @(posedge ref_clk);
    setValid <= 1'h0;
    prefixValid <= 1'h0;
    prefixWord <= ~prefixWord;
  endtask
endmodule // hlc_fetch_model

// [verification/tb_hlc_loop_end_ctrl.sv]
// self-checking testbench of the hardware loop end-mark controller
`timescale 1ns/1ps
`include "hlc_defines.svh"

module tb_hlc_loop_end_ctrl;
  import hlc_pkg::*;
  logic ref_clk = 1'h0; // core clock
  logic arst_n = 1'h0; // async reset, active low
  logic wbCyc = 1'h0;
  logic wbStb = 1'h0;
  logic wbWe = 1'h0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatW = 32'h0;
  logic [31:0] wbDatR;
  logic [31:0] rd; // data of the last bus read
  logic [3:0] selV = 4'hf; // byte enables used by the bus task
  logic wbAck, setValid, prefixValid, fetchRedirect, seqContinue, loopEnd;
  logic [15:0] prefixWord;
  logic [31:0] redirectAddr;
  hlc_slots_t delaySlots;
  logic [3:0] loopActiveFlag, shortLoopFlag;
  int error_cnt = 0;
  int check_count = 0;
  int cycleCnt = 0;
  int redirCnt = 0;
  int endCnt = 0;
  int seqCnt = 0;

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  hlc_loop_end_ctrl hlc_loop_end_ctrl_inst (.ref_clk(ref_clk), .arst_n(arst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
    .setValid(setValid), .prefixValid(prefixValid), .prefixWord(prefixWord), .fetchRedirect(fetchRedirect),
    .redirectAddr(redirectAddr), .delaySlots(delaySlots), .seqContinue(seqContinue), .loopEnd(loopEnd),
    .loopActiveFlag(loopActiveFlag), .shortLoopFlag(shortLoopFlag));

  hlc_fetch_model hlc_fetch_model_inst (.ref_clk(ref_clk), .arst_n(arst_n), .setValid(setValid),
    .prefixValid(prefixValid), .prefixWord(prefixWord));

  // count the one-cycle loop pulses and cut a hang short
  always @(posedge ref_clk) begin
    cycleCnt <= cycleCnt + 1;
    if (fetchRedirect === 1'h1) redirCnt <= redirCnt + 1;
    if (loopEnd === 1'h1) endCnt <= endCnt + 1;
    if (seqContinue === 1'h1) seqCnt <= seqCnt + 1;
    if (cycleCnt == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // compare one value, four-state exact
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one classic wishbone cycle; waits for ack with a bound
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge ref_clk);
    wbCyc <= 1'h1;
    wbStb <= 1'h1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= selV;
    wbDatW <= dat;
    @(posedge ref_clk);
    while (wbAck !== 1'h1 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 50) check("bus ack", 32'h0, 32'h1);
    rd = wbDatR;
    wbCyc <= 1'h0;
    wbStb <= 1'h0;
  endtask

  // load counter and start address of one loop
  task automatic setup(input int idx, input logic [31:0] lc, input logic [31:0] sa);
    wb_cycle(1'h1, `HLC_OFF_LC + 8'(idx) * `HLC_REG_STEP, lc);
    wb_cycle(1'h1, `HLC_OFF_SA + 8'(idx) * `HLC_REG_STEP, sa);
  endtask

  // write active and short flags together
  task automatic flags(input logic [3:0] short_loop_flag, input logic [3:0] lf);
    wb_cycle(1'h1, `HLC_OFF_CTRL, {20'h0, short_loop_flag, 4'h0, lf});
  endtask

  // read a loop counter back
  task automatic check_lc(input int idx, input logic [31:0] exp);
    wb_cycle(1'h0, `HLC_OFF_LC + 8'(idx) * `HLC_REG_STEP, 32'h0);
    check("loop counter", rd, exp);
  endtask

  // one execution set, with or without a prefix carrying early and last-set marks
  task automatic mk(input logic pv, input logic e, input logic l);
    hlc_fetch_model_inst.send(pv, e, l);
  endtask

  // close a set sequence, compare pulse counts and clear them; a negative sequential count is not compared
  task automatic finish(input string name, input int r, input int e, input int s);
    hlc_fetch_model_inst.idle();
    repeat (2) @(posedge ref_clk);
    check("redirect count", 32'(redirCnt), 32'(r));
    check("loop end count", 32'(endCnt), 32'(e));
    if (s >= 0) check("sequential count", 32'(seqCnt), 32'(s));
    redirCnt = 0;
    endCnt = 0;
    seqCnt = 0;
    $display("test %s done", name);
  endtask

  // counts and verdict, then stop
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'h1;
    // long loop: early mark branches, delay-slot marks and a prefixless set do nothing
    setup(0, 32'h3, 32'h100);
    flags(4'h0, 4'h1);
    mk(1, 1, 0);
    mk(1, 1, 1);
    mk(1, 0, 1);
    mk(0, 1, 1);
    finish("long early branch", 1, 0, 0);
    check("redirect address", redirectAddr, 32'h100);
    check("delay slots", {30'h0, delaySlots}, {30'h0, HLC_SLOT2});
    check_lc(0, 32'h2);
    // last-set mark branches at once, then ends the loop; a mark with no loop is dropped
    mk(1, 0, 1);
    finish("last-set branch", 1, 0, 0);
    check("delay slots", {30'h0, delaySlots}, {30'h0, HLC_SLOT0});
    mk(1, 0, 1);
    mk(1, 1, 1);
    finish("last-set end", 0, 1, 1);
    check("active flags", {28'h0, loopActiveFlag}, 32'h0);
    check_lc(0, 32'h0);
    // inner long loop ended by early mark: last-set marks skipped for two sets, then act on outer
    setup(0, 32'h5, 32'h300);
    setup(1, 32'h1, 32'h400);
    flags(4'h0, 4'h3);
    mk(1, 1, 0);
    mk(1, 0, 1);
    mk(1, 0, 1);
    mk(1, 0, 1);
    finish("long early end", 1, 1, -1);
    check("redirect address", redirectAddr, 32'h300);
    check_lc(1, 32'h0);
    check_lc(0, 32'h4);
    // short two-set loop: one delay slot, next set's marks ignored
    setup(0, 32'h3, 32'h200);
    flags(4'h1, 4'h1);
    mk(1, 1, 0);
    mk(1, 1, 1);
    finish("short early branch", 1, 0, 0);
    check("delay slots", {30'h0, delaySlots}, {30'h0, HLC_SLOT1});
    check_lc(0, 32'h2);
    // short inner loop ended by early mark: next set's mark is processed
    setup(0, 32'h4, 32'h500);
    setup(1, 32'h1, 32'h600);
    flags(4'h2, 4'h3);
    mk(1, 1, 0);
    mk(1, 0, 1);
    finish("short early end", 1, 1, -1);
    check("short flags", {28'h0, shortLoopFlag}, 32'h0);
    check_lc(0, 32'h3);
    // single-set short loop driven by last-set marks
    setup(0, 32'h2, 32'h700);
    flags(4'h1, 4'h1);
    mk(1, 0, 1);
    mk(1, 0, 1);
    finish("single set loop", 1, 1, 1);
    check("short flags", {28'h0, shortLoopFlag}, 32'h0);
    check("active flags", {28'h0, loopActiveFlag}, 32'h0);
    // both marks: inner pass only, then inner end chained to outer early branch
    setup(0, 32'h5, 32'h800);
    setup(1, 32'h2, 32'h900);
    flags(4'h0, 4'h3);
    mk(1, 1, 1);
    finish("both marks inner", 1, 0, -1);
    check("redirect address", redirectAddr, 32'h900);
    mk(1, 1, 1);
    mk(1, 1, 1);
    mk(1, 1, 1);
    finish("both marks chain", 1, 1, -1);
    check("redirect address", redirectAddr, 32'h800);
    check("delay slots", {30'h0, delaySlots}, {30'h0, HLC_SLOT2});
    check_lc(1, 32'h0);
    check_lc(0, 32'h4);
    // register access: read-back of flags and an unmapped address
    flags(4'h3, 4'h5);
    wb_cycle(1'h0, `HLC_OFF_CTRL, 32'h0);
    check("control read", rd, 32'h00000305);
    wb_cycle(1'h0, 8'hfc, 32'h0);
    check("unmapped read", rd, 32'h0);
    // status: innermost loop two active, no ignore window
    wb_cycle(1'h0, `HLC_OFF_STAT, 32'h0);
    check("status read", rd, 32'h00000006);
    // byte-masked write touches only the selected lane of loop counter zero
    selV = 4'h2;
    wb_cycle(1'h1, `HLC_OFF_LC, 32'haabbccdd);
    selV = 4'hf;
    check_lc(0, 32'h0000cc04);
    $display("test registers done");
    print_verdict();
  end
endmodule // tb_hlc_loop_end_ctrl
